/* key_event_fifo.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: a row or column joins the matrix only when its membership bit is 1.
// RQ2: configured matrix keys and inputs are watched on every link clock.
// RQ3: matrix key code is ten per row plus column, counted from one.
// RQ4: row input events carry codes 97 to 104 for rows zero to seven.
// RQ5: column input events carry codes 105 to 114 for columns zero to nine.
// RQ6: input events raise interrupts exactly as matrix key events do.
// RQ7: active high input rising is a press, counted and queued.
// RQ8: active low input falling is a press, counted and queued.
// RQ9: after a press the opposite level is armed and queued as release.
// RQ10: event byte is press flag in bit seven and code below it.
// RQ11: locked with event mode lock set, input events are dropped.
// RQ12: ten byte event fifo holds presses and releases.
// RQ13: an input feeds the fifo only when its event mode bit is 1.
// RQ14: flags register sets key or input flag when such an event queues.
// RQ15: low four bits of register three give the stored event count.
// RQ16: head read returns oldest event, decrements count, shifts entries down.
// RQ17: host reads head until count or returned byte is zero.
// RQ18: writing one clears that flag only; other flags stay.
// RQ19: an event arriving with ten stored sets the overflow flag.
// RQ20: overflow with its enable set drives the interrupt pin low.
// RQ21: wrap select 1 appends the new event and discards the oldest.
// RQ22: wrap select 0 drops the new event, contents unchanged.
// RQ23: keypad lock bit six suppresses key event recording and interrupts.
// RQ24: count never exceeds ten; empty head read returns zero, count unchanged.
// RQ25: simultaneous events are queued in fixed order, one per handshake.
module key_event_fifo (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_link,
  input  wire logic [17:0] gpi_pin,
  input  wire logic        key_strobe,
  input  wire logic [2:0]  key_row,
  input  wire logic [3:0]  key_col,
  input  wire logic        key_press,
  output logic             key_ready,
  input  wire logic [17:0] keypad_membership_cfg,
  input  wire logic [17:0] input_event_mode,
  input  wire logic [17:0] input_active_high,
  input  wire logic        input_event_mode_lock,
  input  wire logic        overflow_wrap_select,
  input  wire logic        overflow_irq_enable,
  input  wire logic        event_irq_enable,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  output logic             irq_out,
  output logic             irq_oe
);

  key_event_pkg::link_state_t link_reg;
  key_event_pkg::link_state_t link_next;
  key_event_pkg::sys_state_t  sys_reg;
  key_event_pkg::sys_state_t  sys_next;

  // matrix key code from row and column
  function automatic logic [6:0] matrix_code(input logic [2:0] row, input logic [3:0] col);
    matrix_code = key_event_pkg::KEY_BASE + ({4'h0, row} * key_event_pkg::ROW_STRIDE) + {3'h0, col};
  endfunction

  // input line code: rows then columns
  function automatic logic [6:0] line_code(input int idx);
    if (idx < key_event_pkg::NUM_ROWS) begin
      line_code = key_event_pkg::ROW_GPI_BASE + 7'(idx);
    end else begin
      line_code = key_event_pkg::COL_GPI_BASE + 7'(idx - key_event_pkg::NUM_ROWS);
    end
  endfunction

  // drop first entry, shift the rest down
  function automatic key_event_pkg::key_event_t [9:0] shift_down(input key_event_pkg::key_event_t [9:0] f);
    shift_down = f;
    for (int j = 0; j < key_event_pkg::FIFO_DEPTH - 1; j++) begin
      shift_down[j] = f[j+1];
    end
    shift_down[key_event_pkg::FIFO_DEPTH-1] = 8'h00;
  endfunction

  // link side: sync pins and config, detect events, send one per handshake
  always_comb begin
    logic [17:0] active;
    logic [17:0] line_en;
    logic        sent;
    link_next = link_reg;
    active    = '0;
    line_en   = '0;
    sent      = 1'b0;
    link_next.cfg_meta = '{member: keypad_membership_cfg, event_mode: input_event_mode,
                           active_high: input_active_high};
    link_next.cfg      = link_reg.cfg_meta;
    link_next.pin_meta = gpi_pin;
    link_next.pin_sync = link_reg.pin_meta;
    link_next.ack_meta = sys_reg.ack;
    link_next.ack_sync = link_reg.ack_meta;
    active  = ~(link_reg.pin_sync ^ link_reg.cfg.active_high);                   // RQ7 RQ8
    line_en = ~link_reg.cfg.member & link_reg.cfg.event_mode;                    // RQ13
    // per line press/release detection, armed for the opposite level
    for (int i = 0; i < key_event_pkg::NUM_LINES; i++) begin
      if (!line_en[i]) begin
        // idle until enabled, so stale pins or config give no false edge after reset
        link_next.pressed[i] = 1'b0;
        link_next.pend[i]    = 1'b0;
      end else if (!link_reg.pend[i] && (active[i] != link_reg.pressed[i])) begin // RQ2 RQ9
        link_next.pend[i]       = 1'b1;
        link_next.pend_press[i] = active[i];
        link_next.pressed[i]    = active[i];
      end
    end
    // matrix event capture when both lines belong to the matrix
    if (key_strobe && link_reg.key_ready && ({1'b0, key_row} < 4'(key_event_pkg::NUM_ROWS))
        && (key_col < 4'(key_event_pkg::NUM_COLS))) begin
      if (link_reg.cfg.member[key_row]
          && link_reg.cfg.member[key_event_pkg::NUM_ROWS + 32'(key_col)]) begin    // RQ1
        link_next.mat_pend = 1'b1;
        link_next.mat_ev   = '{press: key_press, code: matrix_code(key_row, key_col)}; // RQ3 RQ10
      end
    end
    // hand one event to the system side: matrix first, then lowest line
    if (link_reg.req == link_reg.ack_sync) begin
      if (link_reg.mat_pend) begin                                                // RQ25
        link_next.data     = link_reg.mat_ev;
        link_next.req      = ~link_reg.req;
        link_next.mat_pend = 1'b0;
      end else begin
        for (int i = 0; i < key_event_pkg::NUM_LINES; i++) begin
          if (!sent && link_reg.pend[i]) begin                                    // RQ25
            sent              = 1'b1;
            link_next.data    = '{press: link_reg.pend_press[i], code: line_code(i)}; // RQ4 RQ5 RQ10
            link_next.req     = ~link_reg.req;
            link_next.pend[i] = 1'b0;
          end
        end
      end
    end
    link_next.key_ready = ~link_next.mat_pend;
  end

  // link side register
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  logic                            new_ev;
  logic                            is_gpi;
  logic                            accept;
  logic                            pop;
  logic                            full;
  key_event_pkg::key_event_t       ev_word;
  key_event_pkg::key_event_t       head_word;

  // event arrival, lock filter and head read decode
  assign new_ev    = sys_reg.req_sync != sys_reg.ack;
  assign ev_word   = link_reg.data;
  assign is_gpi    = ev_word.code >= key_event_pkg::ROW_GPI_BASE;
  assign accept    = new_ev && !(is_gpi ? (sys_reg.lock && input_event_mode_lock) : sys_reg.lock); // RQ11 RQ23
  assign pop       = reg_rd && (reg_addr == key_event_pkg::OFS_HEAD) && (sys_reg.count != 4'h0);
  assign full      = sys_reg.count == key_event_pkg::FIFO_FULL_COUNT;
  assign head_word = sys_reg.fifo[0];

  // system side: fifo, flags, lock, register reads
  always_comb begin
    key_event_pkg::key_event_t [9:0] f;
    logic [3:0]                       cnt;
    sys_next = sys_reg;
    f        = sys_reg.fifo;
    cnt      = sys_reg.count;
    sys_next.req_meta = link_reg.req;
    sys_next.req_sync = sys_reg.req_meta;
    sys_next.ack      = sys_reg.req_sync;
    sys_next.rvalid   = reg_rd;
    // host writes: one clears a flag, lock bit is writable
    if (reg_wr && (reg_addr == key_event_pkg::OFS_FLAGS)) begin
      sys_next.flags = sys_reg.flags & ~reg_wdata;                                // RQ18
    end
    if (reg_wr && (reg_addr == key_event_pkg::OFS_LOCK_COUNT)) begin
      sys_next.lock = reg_wdata[key_event_pkg::LOCK_BIT];                         // RQ23
    end
    // head read pops the oldest entry
    if (pop) begin
      f   = shift_down(f);                                                        // RQ16
      cnt = cnt - 4'h1;
    end
    // push, or overflow handling when ten are stored; set wins over clear
    if (accept) begin
      if (cnt < key_event_pkg::FIFO_FULL_COUNT) begin                             // RQ12 RQ24
        f[cnt] = ev_word;
        cnt    = cnt + 4'h1;
        sys_next.flags[is_gpi ? key_event_pkg::FLAG_INPUT : key_event_pkg::FLAG_KEY] = 1'b1; // RQ6 RQ14
      end else begin
        sys_next.flags[key_event_pkg::FLAG_OVF] = 1'b1;                           // RQ19
        if (overflow_wrap_select) begin
          f = shift_down(f);                                                      // RQ21
          f[key_event_pkg::FIFO_DEPTH-1] = ev_word;
          sys_next.flags[is_gpi ? key_event_pkg::FLAG_INPUT : key_event_pkg::FLAG_KEY] = 1'b1;
        end                                                                       // RQ22
      end
    end
    sys_next.fifo  = f;
    sys_next.count = cnt;
    // read data mux, registered
    unique case (reg_addr)
      key_event_pkg::OFS_FLAGS:      sys_next.rdata = sys_reg.flags;
      key_event_pkg::OFS_LOCK_COUNT: sys_next.rdata = {1'b0, sys_reg.lock, 2'b00, sys_reg.count}; // RQ15
      key_event_pkg::OFS_HEAD:       sys_next.rdata = pop ? head_word : 8'h00;   // RQ24
      default:                       sys_next.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      sys_next.rdata = sys_reg.rdata;
    end
    // open-drain interrupt pin pulled low while an enabled flag is pending
    sys_next.irq_oe = (sys_next.flags[key_event_pkg::FLAG_OVF] && overflow_irq_enable)       // RQ20
                   || ((sys_next.flags[key_event_pkg::FLAG_KEY] || sys_next.flags[key_event_pkg::FLAG_INPUT])
                       && event_irq_enable);                                      // RQ6
    sys_next.irq_out = 1'b0;
  end

  // system side register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // outputs straight from flops
  assign key_ready  = link_reg.key_ready;
  assign reg_rdata  = sys_reg.rdata;
  assign reg_rvalid = sys_reg.rvalid;
  assign irq_out    = sys_reg.irq_out;
  assign irq_oe     = sys_reg.irq_oe;

  // checks on the system side
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_count_bound: assert property (sys_reg.count <= key_event_pkg::FIFO_FULL_COUNT) // RQ24
    else $error("event count above ten");

  a_pop_decrement: assert property (pop && !accept |=> sys_reg.count == $past(sys_reg.count) - 4'h1) // RQ16
    else $error("head read did not decrement count");

  a_pop_head_data: assert property (pop |=> reg_rvalid && reg_rdata == $past(head_word)) // RQ16
    else $error("head read returned wrong byte");

  a_empty_read_zero: assert property (reg_rd && reg_addr == key_event_pkg::OFS_HEAD && sys_reg.count == 4'h0
                                      && !accept |=> reg_rdata == 8'h00 && sys_reg.count == 4'h0) // RQ24
    else $error("empty head read not zero");

  a_drop_keeps_fifo: assert property (accept && full && !overflow_wrap_select && !pop
                                      |=> sys_reg.fifo == $past(sys_reg.fifo)) // RQ22
    else $error("dropped overflow changed fifo");

  a_wrap_tail: assert property (accept && full && overflow_wrap_select && !pop
                                |=> sys_reg.fifo[9] == $past(ev_word) && sys_reg.count == 4'ha) // RQ21
    else $error("wrap did not append at tail");

  a_overflow_flag: assert property (accept && full && !pop |=> sys_reg.flags[key_event_pkg::FLAG_OVF]) // RQ19
    else $error("overflow flag not set");

  a_irq_overflow: assert property (sys_reg.flags[key_event_pkg::FLAG_OVF] && $past(overflow_irq_enable)
                                   |-> irq_oe) // RQ20
    else $error("overflow did not drive interrupt low");

  a_w1c_clear: assert property (reg_wr && reg_addr == key_event_pkg::OFS_FLAGS
                                && reg_wdata[key_event_pkg::FLAG_OVF] && !(accept && full)
                                |=> !sys_reg.flags[key_event_pkg::FLAG_OVF]) // RQ18
    else $error("write one did not clear flag");

  a_lock_drops_key: assert property (new_ev && sys_reg.lock && !is_gpi && !pop
                                     |=> sys_reg.count == $past(sys_reg.count)) // RQ23
    else $error("locked key event was queued");

  a_gpi_flag: assert property (accept && is_gpi && !full |=> sys_reg.flags[key_event_pkg::FLAG_INPUT]) // RQ14
    else $error("input flag not set on queued input event");

  // queue growth and contents on an accepted event or a head read

  a_push_count: assert property (accept && !full && !pop // RQ12
    |=> sys_reg.count == $past(sys_reg.count) + 4'h1)
    else $error("accepted event not counted");

  a_push_data: assert property (accept && !full && !pop // RQ12
    |=> sys_reg.fifo[$past(sys_reg.count)] == $past(ev_word))
    else $error("accepted event not stored at tail");

  a_pop_shift: assert property (pop && !accept // RQ16
    |=> sys_reg.fifo[0] == $past(sys_reg.fifo[1]))
    else $error("head read did not shift entries");

  a_drop_count: assert property (accept && full && !overflow_wrap_select && !pop // RQ22
    |=> sys_reg.count == key_event_pkg::FIFO_FULL_COUNT)
    else $error("dropped overflow changed count");

  // flags and lock filtering

  a_key_flag: assert property (accept && !is_gpi && !full // RQ14
    |=> sys_reg.flags[key_event_pkg::FLAG_KEY])
    else $error("key flag not set on queued key event");

  a_flag_holds: assert property (sys_reg.flags[key_event_pkg::FLAG_KEY] // RQ18
    && !(reg_wr && reg_addr == key_event_pkg::OFS_FLAGS && reg_wdata[key_event_pkg::FLAG_KEY])
    |=> sys_reg.flags[key_event_pkg::FLAG_KEY])
    else $error("key flag cleared without write one");

  a_lock_gpi_mode: assert property (new_ev && is_gpi && sys_reg.lock && input_event_mode_lock && !pop // RQ11
    |=> sys_reg.count == $past(sys_reg.count))
    else $error("locked input event was queued");

  a_gpi_tracked: assert property (new_ev && is_gpi && !input_event_mode_lock && !full && !pop // RQ11
    |=> sys_reg.count == $past(sys_reg.count) + 4'h1)
    else $error("input event lost while tracking allowed");

  a_lock_write: assert property (reg_wr && reg_addr == key_event_pkg::OFS_LOCK_COUNT // RQ23
    |=> sys_reg.lock == $past(reg_wdata[key_event_pkg::LOCK_BIT]))
    else $error("lock bit not written");

  // interrupt pin

  a_irq_event: assert property (sys_reg.flags[key_event_pkg::FLAG_KEY] && $past(event_irq_enable) // RQ6
    |-> irq_oe)
    else $error("key flag did not drive interrupt low");

  a_irq_idle: assert property (sys_reg.flags == 8'h00 // RQ20
    |-> !irq_oe)
    else $error("interrupt driven with no flag pending");

  a_irq_data_low: assert property (!irq_out) // RQ20
    else $error("interrupt data not low");

  // register reads

  a_flags_read: assert property (reg_rd && reg_addr == key_event_pkg::OFS_FLAGS // RQ14
    |=> reg_rdata == $past(sys_reg.flags))
    else $error("flags read wrong");

  a_count_read: assert property (reg_rd && reg_addr == key_event_pkg::OFS_LOCK_COUNT // RQ15
    |=> reg_rdata[3:0] == $past(sys_reg.count) && reg_rdata[6] == $past(sys_reg.lock))
    else $error("count read wrong");

  a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd)) // RQ16
    else $error("read valid not one cycle after read");

  // link side codes

  a_input_code_range: assert property (@(posedge clk_link) link_reg.data.code >= key_event_pkg::ROW_GPI_BASE // RQ5
    |-> link_reg.data.code <= key_event_pkg::COL_GPI_BASE + 7'h09)
    else $error("input code out of range");

  a_matrix_code_range: assert property (@(posedge clk_link) link_reg.mat_pend // RQ3
    |-> link_reg.mat_ev.code >= key_event_pkg::KEY_BASE && link_reg.mat_ev.code < key_event_pkg::ROW_GPI_BASE)
    else $error("matrix code out of range");

  c_fill_full: cover property (accept && full);
  c_locked_drop: cover property (new_ev && !accept);
  c_wrap_event: cover property (accept && full && overflow_wrap_select);
  c_drain_empty: cover property (pop && sys_reg.count == 4'h1);
  c_gpi_queued: cover property (accept && is_gpi);

endmodule

/* key_event_pkg.sv */
package key_event_pkg;
  // fifo geometry and register offsets
  localparam int         FIFO_DEPTH      = 10;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'ha;
  localparam logic [7:0] OFS_FLAGS       = 8'h02;
  localparam logic [7:0] OFS_LOCK_COUNT  = 8'h03;
  localparam logic [7:0] OFS_HEAD        = 8'h04;
  // flag and control bit positions
  localparam int FLAG_KEY   = 0;
  localparam int FLAG_INPUT = 1;
  localparam int FLAG_OVF   = 3;
  localparam int LOCK_BIT   = 6;
  // line layout: rows in 7:0, columns in 17:8
  localparam int NUM_ROWS  = 8;
  localparam int NUM_COLS  = 10;
  localparam int NUM_LINES = 18;
  // key code numbering
  localparam logic [6:0] KEY_BASE      = 7'h01;
  localparam logic [6:0] ROW_STRIDE    = 7'h0a;
  localparam logic [6:0] ROW_GPI_BASE  = 7'h61;
  localparam logic [6:0] COL_GPI_BASE  = 7'h69;
  // reset values
  localparam logic [7:0] FLAGS_RESET   = 8'h00;

  typedef struct packed {
    logic       press;
    logic [6:0] code;
  } key_event_t;

  typedef struct packed {
    logic [NUM_LINES-1:0] member;
    logic [NUM_LINES-1:0] event_mode;
    logic [NUM_LINES-1:0] active_high;
  } line_cfg_t;

  typedef struct packed {
    line_cfg_t            cfg_meta;
    line_cfg_t            cfg;
    logic [NUM_LINES-1:0] pin_meta;
    logic [NUM_LINES-1:0] pin_sync;
    logic [NUM_LINES-1:0] pressed;
    logic [NUM_LINES-1:0] pend;
    logic [NUM_LINES-1:0] pend_press;
    logic                 mat_pend;
    key_event_t           mat_ev;
    logic                 key_ready;
    logic                 req;
    key_event_t           data;
    logic                 ack_meta;
    logic                 ack_sync;
  } link_state_t;

  typedef struct packed {
    logic                        req_meta;
    logic                        req_sync;
    logic                        ack;
    key_event_t [FIFO_DEPTH-1:0] fifo;
    logic [3:0]                  count;
    logic [7:0]                  flags;
    logic                        lock;
    logic [7:0]                  rdata;
    logic                        rvalid;
    logic                        irq_oe;
    logic                        irq_out;
  } sys_state_t;
endpackage

/* key_source.sv */
`timescale 1ns/10ps
// matrix scanner model on the link side of the event slot
module key_source (
  input  wire logic  clk_link,
  input  wire logic  key_ready,
  output logic       key_strobe,
  output logic [2:0] key_row,
  output logic [3:0] key_col,
  output logic       key_press
);
  // idle lines before the first offer
  initial begin
    key_strobe = 1'b0;
    key_row    = 3'h0;
    key_col    = 4'h0;
    key_press  = 1'b0;
  end

  // wait until the slot is ready, offer one event for one link clock, then show stale garbage
  task automatic send(input logic [2:0] r, input logic [3:0] c, input logic p);
    @(negedge clk_link);
    while (key_ready !== 1'b1) @(negedge clk_link);
    @(posedge clk_link);
    key_strobe <= 1'b1;
    key_row    <= r;
    key_col    <= c;
    key_press  <= p;
    @(posedge clk_link);
    key_strobe <= 1'b0;
    key_row    <= ~r;
    key_col    <= ~c;
    key_press  <= ~p;
  endtask
endmodule

/* key_event_fifo_tb_top.sv */
`timescale 1ns/10ps
module key_event_fifo_tb_top;
  logic        clk_sys;
  logic        clk_link;
  logic        rst;
  logic [17:0] gpi_pin;
  logic        key_strobe;
  logic [2:0]  key_row;
  logic [3:0]  key_col;
  logic        key_press;
  logic        key_ready;
  logic        lock_mode;
  logic        wrap_sel;
  logic        ovf_en;
  logic        ev_en;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        irq_oe;
  logic [7:0]  d;
  int          n_mismatch;
  int          n_tests;

  key_source src (.clk_link(clk_link), .key_ready(key_ready), .key_strobe(key_strobe),
    .key_row(key_row), .key_col(key_col), .key_press(key_press));

  // rows 0-3 and columns 0-1 form the matrix; line 7 and line 17 are event inputs
  key_event_fifo dut (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .gpi_pin(gpi_pin),
    .key_strobe(key_strobe), .key_row(key_row), .key_col(key_col), .key_press(key_press),
    .key_ready(key_ready), .keypad_membership_cfg(18'h0030f), .input_event_mode(18'h20080),
    .input_active_high(18'h000ff), .input_event_mode_lock(lock_mode),
    .overflow_wrap_select(wrap_sel), .overflow_irq_enable(ovf_en), .event_irq_enable(ev_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_out(), .irq_oe(irq_oe));

  // two unrelated clocks
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3.7;
    forever #62.5 clk_link = ~clk_link;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // read strobe, then data is taken while the valid pulse stands
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    chk({7'h00, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // poll the event count with a bounded number of reads
  task automatic wait_count(input logic [3:0] n);
    for (int k = 0; k < 60; k++) begin
      rd(8'h03);
      if (d[3:0] === n) break;
      repeat (8) @(posedge clk_sys);
    end
    chk({4'h0, d[3:0]}, {4'h0, n});
  endtask
  task automatic irq(input logic e);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, irq_oe}, {7'h00, e});
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge clk_sys);
    gpi_pin[i] <= v;
  endtask
  // event i: row i%4, column (i/4)%2, press on odd i
  function automatic logic [7:0] ev(input int i);
    return {i[0], 7'(1 + 10 * (i % 4) + (i / 4) % 2)};
  endfunction
  task automatic send_ev(input int i);
    src.send(3'(i % 4), 4'((i / 4) % 2), i[0]);
  endtask
  task automatic quiet;
    repeat (100) @(posedge clk_sys);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end

  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    rst        = 1'b1;
    gpi_pin    = 18'h20000;
    lock_mode  = 1'b0;
    wrap_sel   = 1'b0;
    ovf_en     = 1'b1;
    ev_en      = 1'b1;
    reg_addr   = 8'h00;
    reg_wr     = 1'b0;
    reg_wdata  = 8'h00;
    reg_rd     = 1'b0;
    // asynchronous reset clears both domains at once
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (50) @(posedge clk_sys);
    rdchk(8'h02, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'h03, 8'h00);
    rdchk(8'h07, 8'h00);
    // matrix press, then input presses and releases
    src.send(3'h3, 4'h1, 1'b1);
    wait_count(4'h1);
    rdchk(8'h02, 8'h01);
    irq(1'b1);
    pin(7, 1'b1);
    wait_count(4'h2);
    rdchk(8'h02, 8'h03);
    wr(8'h02, 8'h01);
    rdchk(8'h02, 8'h02);
    wr(8'h02, 8'h02);
    rdchk(8'h02, 8'h00);
    irq(1'b0);
    pin(7, 1'b0);
    wait_count(4'h3);
    pin(17, 1'b0);
    wait_count(4'h4);
    pin(6, 1'b1);
    src.send(3'h5, 4'h0, 1'b1);
    quiet();
    rdchk(8'h03, 8'h04);
    pin(17, 1'b1);
    wait_count(4'h5);
    rdchk(8'h04, 8'ha0);
    rdchk(8'h04, 8'he8);
    rdchk(8'h04, 8'h68);
    rdchk(8'h04, 8'hf2);
    rdchk(8'h04, 8'h72);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h00);
    wr(8'h02, 8'h0b);
    // fill to ten, overflow with drop, then with wrap
    ev_en <= 1'b0;
    for (int i = 0; i < 10; i++) send_ev(i);
    wait_count(4'ha);
    irq(1'b0);
    send_ev(10);
    quiet();
    rdchk(8'h03, 8'h0a);
    rdchk(8'h02, 8'h09);
    irq(1'b1);
    wrap_sel <= 1'b1;
    send_ev(11);
    quiet();
    rdchk(8'h03, 8'h0a);
    for (int i = 1; i < 10; i++) rdchk(8'h04, ev(i));
    rdchk(8'h04, ev(11));
    rdchk(8'h03, 8'h00);
    wr(8'h02, 8'h0b);
    wrap_sel <= 1'b0;
    ev_en    <= 1'b1;
    // locked keypad drops matrix and locked-mode input events
    wr(8'h03, 8'h40);
    rdchk(8'h03, 8'h40);
    lock_mode <= 1'b1;
    src.send(3'h0, 4'h0, 1'b1);
    pin(7, 1'b1);
    quiet();
    rdchk(8'h03, 8'h40);
    rdchk(8'h02, 8'h00);
    lock_mode <= 1'b0;
    pin(17, 1'b0);
    wait_count(4'h1);
    rdchk(8'h04, 8'hf2);
    wr(8'h03, 8'h00);
    final_report();
  end
endmodule
